/* inc/eec_pkg.sv */
// shared constants and types of the 24-bit edge event counter
package eec_pkg;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    localparam int COUNT_W = 24;
    localparam logic [23:0] COUNT_RST = 24'h000000;
    localparam logic [23:0] COUNT_MAX = 24'hffffff;
    localparam logic [23:0] COUNT_ONE = 24'h000001;
    localparam logic WRAP_RST = 1'b0;

    // ------------------------------------------------------------------
    // two-wire slave
    // ------------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h3a;
    localparam logic [4:0] BITS_RST = 5'h00;
    localparam logic [4:0] BITS_ONE = 5'h01;
    localparam logic [4:0] ADDR_BITS = 5'h08;
    localparam logic [4:0] TX_BITS = 5'h18;
    localparam int SYNC_W = 4;
    localparam int SYNC_CNT = 0;
    localparam int SYNC_RUN = 1;
    localparam int SYNC_SCL = 2;
    localparam int SYNC_SDA = 3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_AWAIT = 3'b010,
        ST_AACK  = 3'b011,
        ST_TX    = 3'b100,
        ST_MACK  = 3'b101
    } eec_state_t;

endpackage : eec_pkg

/* hw/eec_sync.sv */
// two-flop synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none

module eec_sync #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    // ------------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
            logic meta;
            logic stab;
            // first stage feeds only the second, never any logic
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta <= 1'b0;
                    stab <= 1'b0;
                end else begin
                    meta <= async_i[gi];
                    stab <= meta;
                end
            end
            assign sync_o[gi] = stab;
        end
    endgenerate

endmodule : eec_sync

`default_nettype wire

/* hw/eec_counter.sv */
// 24-bit rising-edge event counter with two-wire read-out slave
// Function
// - the count is a 24-bit unsigned up-counter covering zero to its all-ones maximum.
// - each low-to-high change of the count input adds exactly one, nothing else does.
// - a counting edge at the maximum wraps the count to zero instead of saturating.
// - the wrap output inverts once for every wrap from maximum to zero.
// - the wrap output is low after power-on until the first wrap.
// - while the counter reset pin is low the count stays cleared and edges are ignored.
// - once the counter reset pin is high, counting edges are counted.
// - the count is read by the bus master over the two-wire serial bus.
// - the data line moves in step with the serial clock and is only pulled low or released.
`timescale 1ns/10ps
`default_nettype none

module eec_counter (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic count_edge_input_i,
    input wire logic count_reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic wrap_o
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // asynchronous assert, release through two flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [eec_pkg::SYNC_W-1:0] pins;
    logic [eec_pkg::SYNC_W-1:0] pins_s;

    // scl is only sampled, never driven
    assign pins = {sda_i, scl_i, count_reset_n_i, count_edge_input_i};

    eec_sync #(
        .W(eec_pkg::SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .async_i(pins),
        .sync_o(pins_s)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0] count;
        logic wrap;
        logic cnt_prev;
        logic scl_prev;
        logic sda_prev;
        eec_pkg::eec_state_t st;
        logic [4:0] bits;
        logic [7:0] addr_sh;
        logic [23:0] tx_sh;
        logic ack_seen;
        logic sda_lvl;
        logic sda_oe;
    } eec_regs_t;

    eec_regs_t r;
    eec_regs_t next_r;

    logic cnt_s;
    logic run_s;
    logic scl_s;
    logic sda_s;
    logic cnt_edge;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign cnt_s = pins_s[eec_pkg::SYNC_CNT];
    assign run_s = pins_s[eec_pkg::SYNC_RUN];
    assign scl_s = pins_s[eec_pkg::SYNC_SCL];
    assign sda_s = pins_s[eec_pkg::SYNC_SDA];

    // edge detection on the second stage outputs only
    assign cnt_edge = cnt_s & ~r.cnt_prev;
    assign scl_rise = scl_s & ~r.scl_prev;
    assign scl_fall = ~scl_s & r.scl_prev;
    assign bus_start = r.scl_prev & scl_s & r.sda_prev & ~sda_s;
    assign bus_stop = r.scl_prev & scl_s & ~r.sda_prev & sda_s;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.cnt_prev = cnt_s;
        next_r.scl_prev = scl_s;
        next_r.sda_prev = sda_s;
        // open drain: the drive value is only ever low
        next_r.sda_lvl = 1'b0;

        // counter: reset pin dominates edges
        if (!run_s) begin
            next_r.count = eec_pkg::COUNT_RST;
        end else if (cnt_edge) begin
            if (r.count == eec_pkg::COUNT_MAX) begin
                next_r.count = eec_pkg::COUNT_RST;
                next_r.wrap = ~r.wrap;
            end else begin
                next_r.count = r.count + eec_pkg::COUNT_ONE;
            end
        end

        // two-wire slave: start and stop override any phase
        if (bus_stop) begin
            next_r.st = eec_pkg::ST_IDLE;
            next_r.sda_oe = 1'b0;
        end else if (bus_start) begin
            next_r.st = eec_pkg::ST_ADDR;
            next_r.bits = eec_pkg::BITS_RST;
            next_r.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                eec_pkg::ST_IDLE: begin
                    next_r.sda_oe = 1'b0;
                end
                eec_pkg::ST_ADDR: begin
                    // address and direction sampled on scl rise
                    if (scl_rise) begin
                        next_r.addr_sh = {r.addr_sh[6:0], sda_s};
                        next_r.bits = r.bits + eec_pkg::BITS_ONE;
                        if (r.bits == eec_pkg::ADDR_BITS - eec_pkg::BITS_ONE) begin
                            next_r.st = eec_pkg::ST_AWAIT;
                        end
                    end
                end
                eec_pkg::ST_AWAIT: begin
                    // only a read to our address is answered; writes are not acknowledged
                    if (scl_fall) begin
                        if (r.addr_sh == {eec_pkg::SLAVE_ADDR, 1'b1}) begin
                            next_r.st = eec_pkg::ST_AACK;
                            next_r.sda_oe = 1'b1;
                            next_r.tx_sh = r.count;
                        end else begin
                            next_r.st = eec_pkg::ST_IDLE;
                        end
                    end
                end
                eec_pkg::ST_AACK: begin
                    // first data bit goes out on the fall after the ack
                    if (scl_fall) begin
                        next_r.st = eec_pkg::ST_TX;
                        next_r.bits = eec_pkg::BITS_RST;
                        next_r.sda_oe = ~r.tx_sh[23];
                    end
                end
                eec_pkg::ST_TX: begin
                    if (scl_rise) begin
                        next_r.bits = r.bits + eec_pkg::BITS_ONE;
                    end else if (scl_fall) begin
                        if (r.bits[2:0] == 3'h0) begin
                            next_r.st = eec_pkg::ST_MACK;
                            next_r.sda_oe = 1'b0;
                        end else begin
                            next_r.tx_sh = {r.tx_sh[22:0], 1'b0};
                            next_r.sda_oe = ~r.tx_sh[22];
                        end
                    end
                end
                eec_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        next_r.ack_seen = ~sda_s;
                    end else if (scl_fall) begin
                        // a nack or the last byte ends the read
                        if (r.ack_seen && (r.bits != eec_pkg::TX_BITS)) begin
                            next_r.st = eec_pkg::ST_TX;
                            next_r.tx_sh = {r.tx_sh[22:0], 1'b0};
                            next_r.sda_oe = ~r.tx_sh[22];
                        end else begin
                            next_r.st = eec_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_r.st = eec_pkg::ST_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // power-on clears the wrap flag; the counter reset pin leaves it alone
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r.count <= eec_pkg::COUNT_RST;
            r.wrap <= eec_pkg::WRAP_RST;
            r.cnt_prev <= 1'b0;
            r.scl_prev <= 1'b0;
            r.sda_prev <= 1'b0;
            r.st <= eec_pkg::ST_IDLE;
            r.bits <= eec_pkg::BITS_RST;
            r.addr_sh <= 8'h00;
            r.tx_sh <= eec_pkg::COUNT_RST;
            r.ack_seen <= 1'b0;
            r.sda_lvl <= 1'b0;
            r.sda_oe <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign sda_o = r.sda_lvl;
    assign sda_oe_o = r.sda_oe;
    assign wrap_o = r.wrap;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    AST_COUNT_INC: assert property (
        (run_s && cnt_edge && r.count != eec_pkg::COUNT_MAX)
        |=> r.count == $past(r.count) + eec_pkg::COUNT_ONE)
        else $error("count did not step by one");
    AST_COUNT_HOLD: assert property (
        (run_s && !cnt_edge) |=> $stable(r.count))
        else $error("count moved without an edge");
    AST_COUNT_WRAP: assert property (
        (run_s && cnt_edge && r.count == eec_pkg::COUNT_MAX)
        |=> (r.count == eec_pkg::COUNT_RST) && (wrap_o != $past(wrap_o)))
        else $error("count did not wrap to zero");
    AST_WRAP_CAUSE: assert property (
        $changed(wrap_o) |-> $past(run_s && cnt_edge && r.count == eec_pkg::COUNT_MAX))
        else $error("wrap flag changed without a wrap");
    AST_HELD_CLEAR: assert property (
        !run_s |=> r.count == eec_pkg::COUNT_RST)
        else $error("count not cleared under counter reset");
    AST_SDA_NEVER_HIGH: assert property (
        sda_o == 1'b0)
        else $error("data line driven high");
    AST_SDA_DRIVE_ON_FALL: assert property (
        $rose(sda_oe_o) |-> $past(scl_fall))
        else $error("data line pulled low away from a clock fall");
    AST_SNAP_STABLE: assert property (
        (r.st == eec_pkg::ST_TX && !scl_fall) |=> $stable(r.tx_sh))
        else $error("snapshot changed mid byte");
    AST_ADDR_ACK: assert property (
        (r.st == eec_pkg::ST_AWAIT && scl_fall && !bus_start && !bus_stop
         && r.addr_sh == {eec_pkg::SLAVE_ADDR, 1'b1})
        |=> sda_oe_o && r.tx_sh == $past(r.count) [*1])
        else $error("read address not acknowledged with snapshot");

endmodule : eec_counter

`default_nettype wire

/* tb/eec_i2c_master.sv */
// bus master model that reads the count over the two-wire link
`timescale 1ns/10ps
`default_nettype none

module eec_i2c_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // clk cycles per scl phase, kept well above the few the slave's synchronisers and edge detect need
    localparam int HALF = 12;

    // scl idles high and stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_clk

    // one scl pulse; data moves a few cycles after the fall so it is never read as start or stop
    task automatic pulse(input logic drive_low, output logic seen);
        wait_clk(3);
        sda_oe_o = drive_low;
        wait_clk(HALF);
        scl_o = 1'b1;
        wait_clk(HALF);
        seen = sda_i;
        scl_o = 1'b0;
    endtask : pulse

    // ------------------------------------------------------------------
    // read frame: start, head byte, ack, three data bytes, stop
    // ------------------------------------------------------------------
    task automatic read(input logic [7:0] head, output logic ack, output logic [23:0] val);
        logic seen;
        val = 24'h000000;
        sda_oe_o = 1'b1;
        wait_clk(HALF);
        scl_o = 1'b0;
        for (int i = 7; i >= 0; i--) pulse(~head[i], seen);
        pulse(1'b0, seen);
        ack = ~seen;
        for (int i = 23; i >= 0; i--) begin
            pulse(1'b0, seen);
            val[i] = seen;
            if (i % 8 == 0) pulse(i != 0, seen); // master nack after the last byte
        end
        wait_clk(3);
        sda_oe_o = 1'b1;
        wait_clk(HALF);
        scl_o = 1'b1;
        wait_clk(HALF);
        sda_oe_o = 1'b0;
        wait_clk(HALF);
    endtask : read
endmodule : eec_i2c_master
`default_nettype wire

/* tb/eec_counter_tb.sv */
// self-checking bench of the edge event counter
`timescale 1ns/10ps
`default_nettype none

module eec_counter_tb;
    typedef struct {
        int n;
        logic [23:0] exp;
    } eec_row_t;

    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic count_edge_input_i = 1'b0;
    logic count_reset_n_i = 1'b1;
    logic sda_o;
    logic sda_oe_o;
    logic wrap_o;
    logic scl_line;
    logic mst_oe;
    wire logic sda_line;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    eec_row_t rows [4] = '{'{1, 24'h000001}, '{7, 24'h000008}, '{0, 24'h000008},
                           '{248, 24'h000100}};

    // open-drain wire with pull-up: low whenever either party pulls
    assign sda_line = ~(sda_oe_o | mst_oe);

    always #10 clk_i = ~clk_i;

    eec_counter dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .count_edge_input_i(count_edge_input_i),
        .count_reset_n_i(count_reset_n_i),
        .scl_i(scl_line),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .wrap_o(wrap_o)
    );

    eec_i2c_master mst (
        .clk_i(clk_i),
        .sda_i(sda_line),
        .scl_o(scl_line),
        .sda_oe_o(mst_oe)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask : check

    // edges at a 160 ns period, high and low four cycles each
    task automatic edges(input int n);
        repeat (n) begin
            @(negedge clk_i) count_edge_input_i = 1'b1;
            repeat (4) @(negedge clk_i);
            count_edge_input_i = 1'b0;
            repeat (3) @(negedge clk_i);
        end
    endtask : edges

    task automatic rd_expect(input logic [23:0] exp, input string what);
        logic ack;
        logic [23:0] val;
        mst.read({eec_pkg::SLAVE_ADDR, 1'b1}, ack, val);
        check(ack === 1'b1, "read not acknowledged");
        check(val === exp, what);
    endtask : rd_expect

    // hang guard, well above the roughly sixteen thousand cycles the sequence takes
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end

    // the device never drives the data wire high; looked at mid-cycle, away from its launch edge
    always @(negedge clk_i) begin
        if (resetn_i && sda_o !== 1'b0) check(1'b0, "data drive not low");
    end

    // ------------------------------------------------------------------
    // main sequence; a wrap needs 2**24 edges, too long to run here
    // ------------------------------------------------------------------
    initial begin : main
        logic ack;
        logic [23:0] val;
        repeat (16) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (8) @(negedge clk_i);
        check(wrap_o === eec_pkg::WRAP_RST, "wrap flag not low after power-on");
        rd_expect(eec_pkg::COUNT_RST, "count not zero after reset");
        foreach (rows[i]) begin
            edges(rows[i].n);
            rd_expect(rows[i].exp, "count after edges");
        end
        // wrong address and write direction are refused
        mst.read({eec_pkg::SLAVE_ADDR ^ 7'h01, 1'b1}, ack, val);
        check(ack === 1'b0, "foreign address acknowledged");
        mst.read({eec_pkg::SLAVE_ADDR, 1'b0}, ack, val);
        check(ack === 1'b0, "write acknowledged");
        // counter reset pin clears and blocks counting, keeps the wrap flag
        count_reset_n_i = 1'b0;
        repeat (5) @(negedge clk_i);
        edges(5);
        rd_expect(24'h000000, "edges counted while held in reset");
        count_reset_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
        edges(3);
        rd_expect(24'h000003, "count after reset release");
        check(wrap_o === 1'b0, "wrap flag moved without a wrap");
        // count through a byte boundary while a read is in flight
        edges(200);
        fork
            mst.read({eec_pkg::SLAVE_ADDR, 1'b1}, ack, val);
            edges(120);
        join
        check(val >= 24'h0000cb && val <= 24'h000143, "torn snapshot");
        rd_expect(24'h000143, "count after read under load");
        // power-on reset in mid-run: count and wrap flag back to their reset values
        resetn_i = 1'b0;
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        // give the reset release and the pin synchronisers time before the next frame
        repeat (8) @(negedge clk_i);
        check(wrap_o === eec_pkg::WRAP_RST, "wrap flag not low after reset");
        rd_expect(eec_pkg::COUNT_RST, "count not zero after mid-run reset");
        summarize();
    end
endmodule : eec_counter_tb
`default_nettype wire
